// [hw/lpw_wake_ctrl.sv]
// low-power idle/stop sequencing, wake-up and interrupt vector arbitration
`timescale 1ns/1ps
`default_nettype none

`include "lpw_params.svh"

module lpw_wake_ctrl #(
  parameter int STAB_CYCLES = `LPW_STAB_CYCLES
) (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // data-space register access
  input wire logic i_dwr,
  input wire logic i_drd,
  input wire logic [7:0] i_daddr,
  input wire logic [7:0] i_dwdata,
  output logic [7:0] o_drdata,
  // core instruction and context
  input wire logic i_idle_exec,
  input wire logic i_stop_exec,
  input wire lpw_pkg::lpw_ctx_t i_ctx,
  input wire logic i_irq_ack,
  input wire logic [2:0] i_ack_vec,
  input wire logic i_wdg_active,
  // peripheral flags and port configuration (same clock)
  input wire lpw_pkg::lpw_flags_t i_flags,
  input wire lpw_pkg::lpw_port_cfg_t i_cfg_a,
  input wire lpw_pkg::lpw_port_cfg_t i_cfg_b,
  input wire lpw_pkg::lpw_port_cfg_t i_cfg_c,
  // external pins
  input wire logic i_nmi_pin_n,
  input wire logic [7:0] i_pin_a,
  input wire logic [7:0] i_pin_b,
  input wire logic [7:0] i_pin_c,
  // core and oscillator control
  output logic o_core_halt,
  output logic o_osc_stop,
  output logic o_wake,
  output logic o_skip,
  output logic o_irq_valid,
  output logic [2:0] o_irq_vec,
  output lpw_pkg::lpw_state_t o_state
);

  localparam int CW = $clog2(STAB_CYCLES + 1);

  typedef struct packed {
    lpw_pkg::lpw_state_t state;
    lpw_pkg::lpw_en_t en;
    logic [24:0] sync1;
    logic [24:0] sync2;
    logic pin1_prev;
    logic pin2_prev;
    logic nmi_prev;
    logic lat0;
    logic lat1;
    logic lat2;
    logic [CW-1:0] stab_cnt;
    logic [7:0] rdata;
    logic wake;
    logic skip;
  } lpw_reg_t;

  lpw_reg_t r_q;
  lpw_reg_t r_d;
  lpw_pkg::lpw_src_t src;
  logic [4:0] pend;
  logic [4:0] take;
  logic any_enabled;
  logic wake_idle;
  logic wake_stop;

  // place a bit into a byte at a fixed position
  function automatic logic [7:0] put(input logic v, input int pos);
    put = v ? 8'(1 << pos) : 8'h00;
  endfunction : put

  // clear a latch on the core's acknowledge for that vector
  function automatic logic acked(input logic [2:0] vec);
    acked = i_irq_ack && (i_ack_vec == vec);
  endfunction : acked

  lpw_irq_map u_map (
    .i_en(r_q.en),
    .i_flags(i_flags),
    .i_cfg_a(i_cfg_a),
    .i_cfg_b(i_cfg_b),
    .i_cfg_c(i_cfg_c),
    .i_pin_a(r_q.sync2[24:17]),
    .i_pin_b(r_q.sync2[16:9]),
    .i_pin_c(r_q.sync2[8:1]),
    .o_src(src)
  );

  // pending requests per vector; level/edge choice per source
  always_comb
  begin
    pend[0] = r_q.lat0;
    pend[1] = r_q.en.level_select ? src.pin1_low : r_q.lat1;
    pend[2] = r_q.lat2 | src.v2_level;
    pend[3] = src.v3_level;
    pend[4] = src.v4_level;
    // maskable sources gated by global enable
    pend[4:1] = pend[4:1] & {4{r_q.en.global_irq_enable}};
    any_enabled = |pend;
    // without global enable nothing wakes, not even non-maskable
    wake_idle = r_q.en.global_irq_enable && any_enabled;
    // stop: only external lines, peripherals have no clock
    wake_stop = r_q.en.global_irq_enable && (pend[0] | pend[1] | r_q.lat2);
  end

  // vector arbitration against the core's context
  always_comb
  begin
    take = 5'h00;
    // non-maskable runs unless already in its own handler
    if (pend[0] && i_ctx != lpw_pkg::LPW_CTX_NMI)
    begin
      take[0] = 1'b1;
    end
    // maskable only from main: no nesting, lowest index wins
    else if (i_ctx == lpw_pkg::LPW_CTX_MAIN)
    begin
      if (pend[1]) take[1] = 1'b1;
      else if (pend[2]) take[2] = 1'b1;
      else if (pend[3]) take[3] = 1'b1;
      else if (pend[4]) take[4] = 1'b1;
    end
    // in maskable context, pending ones wait for return
  end

  // requests reach the core only while it runs
  assign o_irq_valid = (r_q.state == lpw_pkg::LPW_RUN) && (|take);
  always_comb
  begin
    o_irq_vec = 3'h0;
    if (take[1]) o_irq_vec = 3'h1;
    else if (take[2]) o_irq_vec = 3'h2;
    else if (take[3]) o_irq_vec = 3'h3;
    else if (take[4]) o_irq_vec = 3'h4;
  end

  // next-state logic for all registered state
  always_comb
  begin
    r_d = r_q;
    r_d.wake = 1'b0;
    r_d.skip = 1'b0;
    // pins pass two flops; first stage feeds only the second
    r_d.sync1 = {i_pin_a, i_pin_b, i_pin_c, i_nmi_pin_n};
    r_d.sync2 = r_q.sync1;
    r_d.nmi_prev = ~r_q.sync2[0];
    r_d.pin1_prev = src.pin1_low;
    r_d.pin2_prev = r_q.en.edge_select ? src.pin2_high : src.pin2_low;
    // edge latches: clear on acknowledge, a new edge wins
    if (acked(3'h0)) r_d.lat0 = 1'b0;
    if (~r_q.sync2[0] && !r_q.nmi_prev) r_d.lat0 = 1'b1;
    if (acked(3'h1)) r_d.lat1 = 1'b0;
    if (src.pin1_low && !r_q.pin1_prev) r_d.lat1 = 1'b1;
    if (acked(3'h2)) r_d.lat2 = 1'b0;
    if ((r_q.en.edge_select ? src.pin2_high : src.pin2_low) && !r_q.pin2_prev)
      r_d.lat2 = 1'b1;
    // register writes capture enable bits
    if (i_dwr)
    begin
      unique case (i_daddr)
        `LPW_ADDR_INTERRUPT_OPTION:
        begin
          r_d.en.global_irq_enable = i_dwdata[`LPW_BIT_GLOBAL_IRQ_ENABLE];
          r_d.en.level_select = i_dwdata[`LPW_BIT_LEVEL_SELECT];
          r_d.en.edge_select = i_dwdata[`LPW_BIT_EDGE_SELECT];
        end
        `LPW_ADDR_TIMER_STATUS_CONTROL:
          r_d.en.timer_irq_enable = i_dwdata[`LPW_BIT_TIMER_IRQ_ENABLE];
        `LPW_ADDR_ADC_CONTROL:
          r_d.en.converter_irq_enable = i_dwdata[`LPW_BIT_CONVERTER_IRQ_ENABLE];
        `LPW_ADDR_RELOAD_TIMER_MODE_CONTROL:
        begin
          r_d.en.reload_overflow_irq_enable = i_dwdata[`LPW_BIT_RELOAD_OVERFLOW_IRQ_ENABLE];
          r_d.en.reload_compare_irq_enable = i_dwdata[`LPW_BIT_RELOAD_COMPARE_IRQ_ENABLE];
          r_d.en.reload_edge_irq_enable = i_dwdata[`LPW_BIT_RELOAD_EDGE_IRQ_ENABLE];
        end
        `LPW_ADDR_SERIAL_MODE:
          r_d.en.serial_irq_enable = i_dwdata[`LPW_BIT_SERIAL_IRQ_ENABLE];
        default:
          r_d.en = r_q.en;
      endcase
    end
    // reads: enables and flags; interrupt_option is write-only, reads zero
    if (i_drd)
    begin
      unique case (i_daddr)
        `LPW_ADDR_TIMER_STATUS_CONTROL:
          r_d.rdata = put(r_q.en.timer_irq_enable, `LPW_BIT_TIMER_IRQ_ENABLE)
            | put(i_flags.timer_zero_flag, `LPW_BIT_TIMER_ZERO_FLAG);
        `LPW_ADDR_ADC_CONTROL:
          r_d.rdata = put(r_q.en.converter_irq_enable, `LPW_BIT_CONVERTER_IRQ_ENABLE)
            | put(i_flags.converter_done_flag, `LPW_BIT_CONVERTER_DONE_FLAG);
        `LPW_ADDR_RELOAD_TIMER_MODE_CONTROL:
          r_d.rdata = put(r_q.en.reload_overflow_irq_enable,
              `LPW_BIT_RELOAD_OVERFLOW_IRQ_ENABLE)
            | put(r_q.en.reload_compare_irq_enable, `LPW_BIT_RELOAD_COMPARE_IRQ_ENABLE)
            | put(r_q.en.reload_edge_irq_enable, `LPW_BIT_RELOAD_EDGE_IRQ_ENABLE)
            | put(i_flags.reload_overflow_flag, `LPW_BIT_RELOAD_OVERFLOW_FLAG)
            | put(i_flags.reload_compare_flag, `LPW_BIT_RELOAD_COMPARE_FLAG)
            | put(i_flags.reload_edge_flag, `LPW_BIT_RELOAD_EDGE_FLAG);
        `LPW_ADDR_SERIAL_MODE:
          r_d.rdata = put(r_q.en.serial_irq_enable, `LPW_BIT_SERIAL_IRQ_ENABLE)
            | put(!i_flags.serial_done, `LPW_BIT_SERIAL_TRANSFER_ACTIVE);
        default:
          r_d.rdata = `LPW_RST_BYTE;
      endcase
    end
    // power state sequencing
    unique case (r_q.state)
      lpw_pkg::LPW_RUN:
      begin
        if (i_idle_exec || i_stop_exec)
        begin
          // a pending enabled request makes the instruction a no-op
          if (any_enabled)
            r_d.skip = 1'b1;
          // watchdog running forces idle instead of stop
          else if (i_stop_exec && !i_wdg_active)
            r_d.state = lpw_pkg::LPW_STOP;
          else
            r_d.state = lpw_pkg::LPW_IDLE;
        end
      end
      lpw_pkg::LPW_IDLE:
      begin
        // oscillator kept, so the core restarts on the next edge
        if (wake_idle)
        begin
          r_d.state = lpw_pkg::LPW_RUN;
          r_d.wake = 1'b1;
        end
      end
      lpw_pkg::LPW_STOP:
      begin
        if (wake_stop)
        begin
          r_d.state = lpw_pkg::LPW_STAB;
          r_d.stab_cnt = CW'(STAB_CYCLES - 1);
        end
      end
      lpw_pkg::LPW_STAB:
      begin
        // hold the core until the oscillator has settled
        if (r_q.stab_cnt == '0)
        begin
          r_d.state = lpw_pkg::LPW_RUN;
          r_d.wake = 1'b1;
        end
        else
          r_d.stab_cnt = r_q.stab_cnt - CW'(1);
      end
    endcase
  end

  // one register stage; reset drops any low-power state
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      r_q <= '0;
      r_q.state <= lpw_pkg::LPW_RUN;
      r_q.en <= `LPW_RST_ENABLES;
      r_q.sync1 <= '1;
      r_q.sync2 <= '1;
      r_q.rdata <= `LPW_RST_BYTE;
    end
    else if (i_ce)
      r_q <= r_d;
  end

  // core frozen outside run; peripherals and RAM untouched
  assign o_core_halt = (r_q.state != lpw_pkg::LPW_RUN);
  // oscillator only stops in deep stop; selection never changed here
  assign o_osc_stop = (r_q.state == lpw_pkg::LPW_STOP);
  assign o_wake = r_q.wake;
  assign o_skip = r_q.skip;
  assign o_drdata = r_q.rdata;
  assign o_state = r_q.state;

endmodule : lpw_wake_ctrl

`default_nettype wire

// [hw/lpw_params.svh]
// constants for the low-power wake controller: offsets, bit positions, resets, timing
`ifndef LPW_PARAMS_SVH
`define LPW_PARAMS_SVH

// data-space offsets of the registers this block answers
`define LPW_ADDR_INTERRUPT_OPTION 8'hC8
`define LPW_ADDR_ADC_CONTROL 8'hD1
`define LPW_ADDR_TIMER_STATUS_CONTROL 8'hD4
`define LPW_ADDR_RELOAD_TIMER_MODE_CONTROL 8'hD5
`define LPW_ADDR_SERIAL_MODE 8'hE2

// interrupt_option field positions
`define LPW_BIT_LEVEL_SELECT 6
`define LPW_BIT_EDGE_SELECT 5
`define LPW_BIT_GLOBAL_IRQ_ENABLE 4

// enable and flag positions in the peripheral control registers
`define LPW_BIT_TIMER_ZERO_FLAG 7
`define LPW_BIT_TIMER_IRQ_ENABLE 6
`define LPW_BIT_CONVERTER_IRQ_ENABLE 5
`define LPW_BIT_CONVERTER_DONE_FLAG 6
`define LPW_BIT_RELOAD_OVERFLOW_IRQ_ENABLE 7
`define LPW_BIT_RELOAD_COMPARE_IRQ_ENABLE 6
`define LPW_BIT_RELOAD_EDGE_IRQ_ENABLE 5
`define LPW_BIT_RELOAD_OVERFLOW_FLAG 2
`define LPW_BIT_RELOAD_COMPARE_FLAG 1
`define LPW_BIT_RELOAD_EDGE_FLAG 0
`define LPW_BIT_SERIAL_IRQ_ENABLE 7
`define LPW_BIT_SERIAL_TRANSFER_ACTIVE 6

// reset values
`define LPW_RST_ENABLES 9'h000
`define LPW_RST_BYTE 8'h00

// oscillator settling after deep stop
`define LPW_STAB_TIME_NS 204800
`define LPW_CLK_PERIOD_NS 50
`define LPW_STAB_CYCLES ((`LPW_STAB_TIME_NS + `LPW_CLK_PERIOD_NS - 1) / `LPW_CLK_PERIOD_NS)

`endif

// [hw/lpw_pkg.sv]
// types shared by the low-power wake controller
package lpw_pkg;

  // power state of the core
  typedef enum logic [1:0] {LPW_RUN, LPW_IDLE, LPW_STOP, LPW_STAB} lpw_state_t;

  // execution context reported by the core
  typedef enum logic [1:0] {LPW_CTX_MAIN, LPW_CTX_IRQ, LPW_CTX_NMI} lpw_ctx_t;

  // enable bits captured from register writes
  typedef struct packed {
    logic global_irq_enable;
    logic level_select;
    logic edge_select;
    logic timer_irq_enable;
    logic converter_irq_enable;
    logic reload_overflow_irq_enable;
    logic reload_compare_irq_enable;
    logic reload_edge_irq_enable;
    logic serial_irq_enable;
  } lpw_en_t;

  // peripheral event flags
  typedef struct packed {
    logic timer_zero_flag;
    logic converter_done_flag;
    logic reload_overflow_flag;
    logic reload_compare_flag;
    logic reload_edge_flag;
    logic serial_done;
  } lpw_flags_t;

  // one port's configuration bits
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] opt;
    logic [7:0] data;
  } lpw_port_cfg_t;

  // level requests from the source map
  typedef struct packed {
    logic pin1_low;
    logic pin2_low;
    logic pin2_high;
    logic v2_level;
    logic v3_level;
    logic v4_level;
  } lpw_src_t;

endpackage : lpw_pkg

// [hw/lpw_irq_map.sv]
// maps peripheral flags and port pin lines onto interrupt vector requests
`timescale 1ns/1ps
`default_nettype none

module lpw_irq_map (
  // enables and flags
  input wire lpw_pkg::lpw_en_t i_en,
  input wire lpw_pkg::lpw_flags_t i_flags,
  // port configuration and synchronised pin levels
  input wire lpw_pkg::lpw_port_cfg_t i_cfg_a,
  input wire lpw_pkg::lpw_port_cfg_t i_cfg_b,
  input wire lpw_pkg::lpw_port_cfg_t i_cfg_c,
  input wire logic [7:0] i_pin_a,
  input wire logic [7:0] i_pin_b,
  input wire logic [7:0] i_pin_c,
  // mapped requests
  output lpw_pkg::lpw_src_t o_src
);

  // a line interrupts when input, option set and data clear
  function automatic logic [7:0] line_en(input lpw_pkg::lpw_port_cfg_t c);
    line_en = ~c.dir & c.opt & ~c.data;
  endfunction : line_en

  logic [7:0] en_a;
  logic [7:0] en_b;
  logic [7:0] en_c;

  assign en_a = line_en(i_cfg_a);
  assign en_b = line_en(i_cfg_b);
  assign en_c = line_en(i_cfg_c);

  // port A/B on vector 1, port C on vector 2
  assign o_src.pin1_low = |((en_a & ~i_pin_a) | (en_b & ~i_pin_b));
  assign o_src.pin2_low = |(en_c & ~i_pin_c);
  assign o_src.pin2_high = |(en_c & i_pin_c);
  // serial end-of-transfer on vector 2
  assign o_src.v2_level = i_flags.serial_done & i_en.serial_irq_enable;
  // reload timer events merged on vector 3
  assign o_src.v3_level = (i_flags.reload_overflow_flag & i_en.reload_overflow_irq_enable)
    | (i_flags.reload_compare_flag & i_en.reload_compare_irq_enable)
    | (i_flags.reload_edge_flag & i_en.reload_edge_irq_enable);
  // timer zero and converter done share vector 4
  assign o_src.v4_level = (i_flags.timer_zero_flag & i_en.timer_irq_enable)
    | (i_flags.converter_done_flag & i_en.converter_irq_enable);

endmodule : lpw_irq_map

`default_nettype wire

// [tb/lpw_core_model.sv]
// behavioural model of the core that acknowledges offered interrupt requests
`timescale 1ns/1ps
`default_nettype none
module lpw_core_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // acknowledge on or off, and its lag in cycles
  input wire logic i_on,
  input wire logic [1:0] i_lag,
  // request from the block
  input wire logic i_irq_valid,
  input wire logic [2:0] i_irq_vec,
  input wire logic i_halt,
  // handler start towards the block
  output logic o_ack,
  output logic [2:0] o_ack_vec
);
  logic [1:0] wait_q;
  // a halted core takes nothing; the vector is scrambled outside an ack
  always @(posedge i_mclk)
  begin
    o_ack <= 1'b0;
    o_ack_vec <= ~o_ack_vec;
    if (i_sys_rst || !i_on || !i_irq_valid || i_halt || o_ack)
      wait_q <= 2'd0;
    else if (wait_q == i_lag)
    begin
      o_ack <= 1'b1;
      o_ack_vec <= i_irq_vec;
    end
    else
      wait_q <= wait_q + 2'd1;
  end
endmodule : lpw_core_model
`default_nettype wire

// [tb/lpw_wake_ctrl_asserts.sv]
// concurrent checks on the ports of the low-power wake controller
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl_chk #(
  parameter int STAB_CYCLES = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // inputs watched
  input wire logic i_ce,
  input wire logic i_dwr,
  input wire logic [7:0] i_daddr,
  input wire logic [7:0] i_dwdata,
  input wire logic i_idle_exec,
  input wire logic i_stop_exec,
  input wire lpw_pkg::lpw_ctx_t i_ctx,
  input wire logic i_wdg_active,
  // outputs watched
  input wire logic o_core_halt,
  input wire logic o_osc_stop,
  input wire logic o_wake,
  input wire logic o_skip,
  input wire logic o_irq_valid,
  input wire logic [2:0] o_irq_vec,
  input wire lpw_pkg::lpw_state_t o_state
);
  logic gen_q;
  logic [15:0] cnt_q;
  // shadow of the global enable, as the register is write-only
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      gen_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else if (i_ce)
    begin
      if (i_dwr && i_daddr == 8'hC8)
        gen_q <= i_dwdata[4];
      cnt_q <= (o_state == lpw_pkg::LPW_STAB) ? cnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  a_idle_entry: assert property (
    i_ce && i_idle_exec && o_state == lpw_pkg::LPW_RUN |=> o_state == lpw_pkg::LPW_IDLE || o_skip)
    else $error("idle not entered");
  a_stop_entry: assert property (
    i_ce && i_stop_exec && !i_wdg_active && o_state == lpw_pkg::LPW_RUN
    |=> (o_state == lpw_pkg::LPW_STOP && o_osc_stop) || o_skip) else $error("stop not entered");
  a_stop_wdg: assert property (
    i_ce && i_stop_exec && i_wdg_active && o_state == lpw_pkg::LPW_RUN
    |=> o_state == lpw_pkg::LPW_IDLE || o_skip) else $error("stop with watchdog");
  a_idle_exit: assert property (
    o_state == lpw_pkg::LPW_IDLE |=> o_state == lpw_pkg::LPW_IDLE
    || (o_state == lpw_pkg::LPW_RUN && o_wake)) else $error("bad idle exit");
  a_settle_len: assert property (
    o_state == lpw_pkg::LPW_RUN && $past(o_state) == lpw_pkg::LPW_STAB && !$past(i_sys_rst)
    |-> o_wake && cnt_q >= STAB_CYCLES && cnt_q <= STAB_CYCLES + 1) else $error("settle length");
  a_halt_match: assert property (
    o_core_halt == (o_state != lpw_pkg::LPW_RUN) && o_osc_stop == (o_state == lpw_pkg::LPW_STOP))
    else $error("halt or oscillator stop wrong");
  a_gen_hold: assert property (
    o_state == lpw_pkg::LPW_IDLE && !gen_q |=> o_state == lpw_pkg::LPW_IDLE)
    else $error("woke with enable off");
  a_gen_mask: assert property (
    o_irq_valid && !gen_q |-> o_irq_vec == 3'h0) else $error("maskable offered");
  a_nmi_ctx: assert property (
    i_ctx == lpw_pkg::LPW_CTX_NMI |-> !o_irq_valid) else $error("offer in nmi context");
  a_irq_ctx: assert property (
    i_ctx == lpw_pkg::LPW_CTX_IRQ && o_irq_valid |-> o_irq_vec == 3'h0)
    else $error("maskable pre-empts handler");
  // main scenarios reached
  c_idle_wake: cover property (o_state == lpw_pkg::LPW_IDLE ##1 o_state == lpw_pkg::LPW_RUN);
  c_stop_wake: cover property (o_state == lpw_pkg::LPW_STAB ##1 o_state == lpw_pkg::LPW_RUN);
  c_skip: cover property (o_skip);
endmodule : lpw_wake_ctrl_chk
bind lpw_wake_ctrl lpw_wake_ctrl_chk #(.STAB_CYCLES(STAB_CYCLES)) chk (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_dwr(i_dwr), .i_daddr(i_daddr), .i_dwdata(i_dwdata),
  .i_idle_exec(i_idle_exec), .i_stop_exec(i_stop_exec), .i_ctx(i_ctx),
  .i_wdg_active(i_wdg_active), .o_core_halt(o_core_halt), .o_osc_stop(o_osc_stop),
  .o_wake(o_wake), .o_skip(o_skip), .o_irq_valid(o_irq_valid), .o_irq_vec(o_irq_vec),
  .o_state(o_state));
`default_nettype wire

// [tb/test_low_power_wake_control.sv]
// self-checking bench for the low-power wake controller
`timescale 1ns/1ps
`default_nettype none
module test_low_power_wake_control;
  localparam int SC = 8;
  localparam lpw_pkg::lpw_state_t RUN = lpw_pkg::LPW_RUN;
  localparam lpw_pkg::lpw_state_t IDL = lpw_pkg::LPW_IDLE;
  localparam lpw_pkg::lpw_state_t STP = lpw_pkg::LPW_STOP;
  localparam lpw_pkg::lpw_state_t STB = lpw_pkg::LPW_STAB;
  logic clk = 0, rst = 1, dwr = 0, drd = 0, idle = 0, stop = 0, wdg = 0, nmi_n = 1, on = 0;
  logic ce = 1;
  logic ack, halt, osc, wake, skip, valid;
  logic [1:0] lag = 0;
  logic [2:0] ack_vec, vec;
  logic [7:0] addr = 0, wd = 0, pa = 8'hFF, pc = 8'hFF, rdat;
  logic [7:0] vt [6] = '{8'h0A, 8'h0B, 8'h0B, 8'h0B, 8'h0C, 8'h0C};
  lpw_pkg::lpw_ctx_t ctx = lpw_pkg::LPW_CTX_MAIN;
  lpw_pkg::lpw_flags_t fl = '0;
  lpw_pkg::lpw_port_cfg_t cfa = '0;
  lpw_pkg::lpw_port_cfg_t cfc = '0;
  lpw_pkg::lpw_state_t state;
  int error_cnt = 0, checked = 0, n;
  wire logic [7:0] stat = {2'b00, halt, osc, wake, skip, state};
  wire logic [7:0] irq = valid ? {5'h01, vec} : 8'h00;
  // 20 MHz clock
  always #25 clk = ~clk;
  lpw_wake_ctrl #(.STAB_CYCLES(SC)) dut (.i_mclk(clk), .i_sys_rst(rst), .i_ce(ce),
    .i_dwr(dwr), .i_drd(drd), .i_daddr(addr), .i_dwdata(wd), .o_drdata(rdat),
    .i_idle_exec(idle), .i_stop_exec(stop), .i_ctx(ctx), .i_irq_ack(ack), .i_ack_vec(ack_vec),
    .i_wdg_active(wdg), .i_flags(fl), .i_cfg_a(cfa), .i_cfg_b('0), .i_cfg_c(cfc),
    .i_nmi_pin_n(nmi_n), .i_pin_a(pa), .i_pin_b(8'hFF), .i_pin_c(pc), .o_core_halt(halt),
    .o_osc_stop(osc), .o_wake(wake), .o_skip(skip), .o_irq_valid(valid), .o_irq_vec(vec),
    .o_state(state));
  lpw_core_model core (.i_mclk(clk), .i_sys_rst(rst), .i_on(on), .i_lag(lag),
    .i_irq_valid(valid), .i_irq_vec(vec), .i_halt(halt), .o_ack(ack), .o_ack_vec(ack_vec));
  // inputs move 5 ns after the edge so sampling never races
  task automatic cyc(input int k = 1);
    repeat (k) @(posedge clk);
    #5;
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // strobe dropped for a cycle so it is never set twice in one step
  task automatic wr(input logic [7:0] a, d);
    addr = a;
    wd = d;
    dwr = 1'b1;
    cyc();
    dwr = 1'b0;
    cyc();
  endtask : wr
  task automatic rd(input logic [7:0] a, m, e, input string nm);
    addr = a;
    drd = 1'b1;
    cyc();
    drd = 1'b0;
    chk(nm, e, rdat & m);
    cyc();
  endtask : rd
  task automatic lp(input logic s);
    idle = !s;
    stop = s;
    cyc();
    idle = 1'b0;
    stop = 1'b0;
  endtask : lp
  task automatic wt(input lpw_pkg::lpw_state_t s, input int lim);
    n = 0;
    while (state !== s && n < lim)
    begin
      cyc();
      n++;
    end
  endtask : wt
  function automatic logic [7:0] st(input logic h, o, w, k, input lpw_pkg::lpw_state_t s);
    return {2'b00, h, o, w, k, s};
  endfunction : st
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // hang guard, far beyond the roughly 125 cycles the tests take
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  // test sequence
  initial
  begin
    cyc(5);
    rst = 1'b0;
    cyc();
    chk("state", st(0, 0, 0, 0, RUN), stat);
    rd(8'hC8, 8'hFF, 8'h00, "interrupt_option");
    rd(8'h00, 8'hFF, 8'h00, "unmapped");
    wr(8'hC8, 8'h10);
    wr(8'hD4, 8'h40);
    wr(8'hD1, 8'h20);
    wr(8'hD5, 8'hE0);
    wr(8'hE2, 8'h80);
    rd(8'hE2, 8'hC0, 8'hC0, "serial_mode");
    fl = 6'h20;
    rd(8'hD4, 8'hC0, 8'hC0, "timer_status_control");
    $display("test registers over");
    for (int i = 0; i < 6; i++)
    begin
      fl = 6'(1 << i);
      cyc();
      chk("vector", vt[i], irq);
    end
    fl = 6'h3F;
    cyc();
    chk("priority", 8'h0A, irq);
    wr(8'hC8, 8'h00);
    chk("masked", 8'h00, irq);
    wr(8'hC8, 8'h10);
    lp(0);
    chk("skip", st(0, 0, 0, 1, RUN), stat);
    fl = '0;
    $display("test sources over");
    on = 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      ctx = lpw_pkg::lpw_ctx_t'(c);
      lp(0);
      cyc(3);
      chk("idle", st(1, 0, 0, 0, IDL), stat);
      fl = 6'h20;
      cyc();
      chk("idle wake", st(0, 0, 1, 0, RUN), stat);
      chk("context", (c == 0) ? 8'h0C : 8'h00, irq);
      fl = '0;
      cyc();
    end
    ctx = lpw_pkg::LPW_CTX_IRQ;
    lag = 2'd3;
    lp(0);
    nmi_n = 1'b0;
    wt(RUN, 10);
    chk("nmi wake", 8'h08, irq);
    nmi_n = 1'b1;
    cyc(8);
    chk("nmi taken", 8'h00, irq);
    ctx = lpw_pkg::LPW_CTX_MAIN;
    lag = 2'd0;
    $display("test idle over");
    wdg = 1'b1;
    lp(1);
    chk("stop as idle", st(1, 0, 0, 0, IDL), stat);
    fl = 6'h20;
    cyc();
    chk("watchdog wake", st(0, 0, 1, 0, RUN), stat);
    fl = '0;
    wdg = 1'b0;
    cfa = 24'h000100;
    cyc();
    lp(1);
    fl = 6'h20;
    cyc(4);
    chk("stop", st(1, 1, 0, 0, STP), stat);
    fl = '0;
    pa = 8'hFE;
    wt(STB, 8);
    chk("settle", st(1, 0, 0, 0, STB), stat);
    wt(RUN, 20);
    chk("settle length", 8'h01, 8'((n >= SC) && (n <= SC + 1)));
    chk("stop wake", st(0, 0, 1, 0, RUN), stat);
    chk("pin vector", 8'h09, irq);
    pa = 8'hFF;
    cyc(3);
    chk("pin taken", 8'h00, irq);
    // port C falling edge is stored until the core takes vector 2
    on = 1'b0;
    cfc = 24'h000100;
    pc = 8'hFE;
    cyc(4);
    chk("port c vector", 8'h0A, irq);
    pc = 8'hFF;
    cyc(3);
    chk("port c held", 8'h0A, irq);
    on = 1'b1;
    cyc(3);
    chk("port c taken", 8'h00, irq);
    on = 1'b0;
    // level mode on vector 1 follows the pin, nothing stored
    wr(8'hC8, 8'h50);
    pa = 8'hFE;
    cyc(3);
    chk("level vector", 8'h09, irq);
    pa = 8'hFF;
    cyc(3);
    chk("level gone", 8'h00, irq);
    $display("test stop over");
    on = 1'b0;
    wr(8'hC8, 8'h00);
    lp(0);
    fl = 6'h20;
    nmi_n = 1'b0;
    cyc(6);
    chk("no wake", st(1, 0, 0, 0, IDL), stat);
    rst = 1'b1;
    cyc();
    rst = 1'b0;
    chk("reset exit", st(0, 0, 0, 0, RUN), stat);
    fl = '0;
    cyc(4);
    chk("nmi unmasked", 8'h08, irq);
    // enable low: a pending request must not even produce a skip
    ce = 1'b0;
    lp(0);
    chk("frozen", st(0, 0, 0, 0, RUN), stat);
    ce = 1'b1;
    nmi_n = 1'b1;
    $display("test reset over");
    print_verdict();
  end
endmodule : test_low_power_wake_control
`default_nettype wire
